// ===== core/lbw_cfg_regs.sv
// Behaviour
// - offset 0x04 holds regulator-3 select, three discharge enables, step-up select; resets 0xBA.
// - bits 7:6 pick regulator-3 voltage: 00 1.2V, 01 1.5V, 11 2.5V, 10 default.
// - bits 2:0 pick step-up output 13.0V plus 0.5V per code; 010 default.
// - offset 0x05 holds main LED code; current is code plus one times 0.1mA.
// - code all ones gives 25.6mA maximum, all zeros gives the minimum.
module lbw_cfg_regs (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  output logic      [7:0]         reg_rdata_o,
  output logic                    reg_rvalid_o,
  output logic                    reg_miss_o,
  output lbw_pkg::lbw_setup_t     setup_o,
  output logic      [7:0]         main_current_code_o,
  output lbw_pkg::lbw_analog_t    analog_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic hit_setup;
  logic hit_main;
  logic wr_setup;
  logic wr_main;

  assign hit_setup = (reg_addr_i == lbw_pkg::ADDR_SETUP);
  assign hit_main  = (reg_addr_i == lbw_pkg::ADDR_MAIN_CUR);
  assign wr_setup  = reg_wr_i && hit_setup;
  assign wr_main   = reg_wr_i && hit_main;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] setup_raw;

  // setup register, power-on 0xBA
  lbw_reg8 #(
    .RST_VAL (lbw_pkg::SETUP_RST)
  ) u_setup (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (wr_setup),
    .d_i     (reg_wdata_i),
    .q_o     (setup_raw)
  );

  // main current code, power-on 0x01
  lbw_reg8 #(
    .RST_VAL (lbw_pkg::MAIN_CUR_RST)
  ) u_main (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (wr_main),
    .d_i     (reg_wdata_i),
    .q_o     (main_current_code_o)
  );

  assign setup_o = lbw_pkg::lbw_setup_t'(setup_raw);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       rvalid_d;
  logic       rvalid_q;
  logic       miss_d;
  logic       miss_q;

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    miss_d   = 1'b0;
    if (reg_rd_i) begin
      rvalid_d = 1'b1;
      if (hit_setup) begin
        rdata_d = setup_raw;
      end else if (hit_main) begin
        rdata_d = main_current_code_o;
      end else begin
        rdata_d = lbw_pkg::UNMAPPED_READ;
        miss_d  = 1'b1;
      end
    end else if (reg_wr_i && !hit_setup && !hit_main) begin
      miss_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
      miss_q   <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      miss_q   <= miss_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign reg_miss_o   = miss_q;

  // ----------------------------------------------------------------
  // decode of analog settings
  // ----------------------------------------------------------------
  lbw_pkg::lbw_analog_t analog_d;
  lbw_pkg::lbw_analog_t analog_q;
  logic [1:0]           reg3_sel;
  logic [2:0]           stepup_sel;

  assign reg3_sel   = {setup_o.reg3_volt_sel_hi, setup_o.reg3_volt_sel_lo};
  assign stepup_sel = {setup_o.stepup_volt_sel_b2, setup_o.stepup_volt_sel_b1,
                       setup_o.stepup_volt_sel_b0};

  always_comb begin
    analog_d = analog_q;
    case (reg3_sel)
      lbw_pkg::REG3_SEL_1V2: analog_d.reg3_mv = lbw_pkg::REG3_MV_1V2;
      lbw_pkg::REG3_SEL_1V5: analog_d.reg3_mv = lbw_pkg::REG3_MV_1V5;
      lbw_pkg::REG3_SEL_2V5: analog_d.reg3_mv = lbw_pkg::REG3_MV_2V5;
      default:               analog_d.reg3_mv = lbw_pkg::REG3_MV_DEF;
    endcase
    // 13.0 V plus 0.5 V per code
    analog_d.stepup_dv  = 8'(lbw_pkg::STEPUP_DV_BASE
                             + 8'(lbw_pkg::STEPUP_DV_STEP * {5'h00, stepup_sel}));
    // code plus one, in 0.1 mA steps
    analog_d.sink_steps = 9'({1'b0, main_current_code_o} + 9'h001);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      analog_q.reg3_mv    <= lbw_pkg::REG3_MV_DEF;
      analog_q.stepup_dv  <= lbw_pkg::STEPUP_DV_RST;
      analog_q.sink_steps <= lbw_pkg::SINK_STEPS_RST;
    end else begin
      analog_q <= analog_d;
    end
  end

  assign analog_o = analog_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (!rst_n_i);

  sequence s_wr_setup;
    rst_n_i && reg_wr_i && (reg_addr_i == lbw_pkg::ADDR_SETUP);
  endsequence

  sequence s_rd_main;
    rst_n_i && reg_rd_i && !reg_wr_i && (reg_addr_i == lbw_pkg::ADDR_MAIN_CUR);
  endsequence

  sequence s_rd_setup;
    rst_n_i && reg_rd_i && !reg_wr_i && (reg_addr_i == lbw_pkg::ADDR_SETUP);
  endsequence

  a_setup_load: assert property (
    s_wr_setup |=> (setup_raw == $past(reg_wdata_i)) ##1
                   (analog_o.stepup_dv == 8'(lbw_pkg::STEPUP_DV_BASE
                    + 8'(lbw_pkg::STEPUP_DV_STEP * {5'h00, $past(reg_wdata_i, 2) & 8'h07}))))
    else $error("setup write not stored or not decoded");

  a_reset_values: assert property (
    !$past(rst_n_i) |-> (setup_raw == lbw_pkg::SETUP_RST)
                        && (main_current_code_o == lbw_pkg::MAIN_CUR_RST)
                        && (analog_o.sink_steps == lbw_pkg::SINK_STEPS_RST))
    else $error("power-on values wrong after reset");

  a_reg3_volts: assert property (
    rst_n_i |=> analog_o.reg3_mv ==
      (($past(reg3_sel) == lbw_pkg::REG3_SEL_1V2) ? lbw_pkg::REG3_MV_1V2 :
       ($past(reg3_sel) == lbw_pkg::REG3_SEL_1V5) ? lbw_pkg::REG3_MV_1V5 :
       ($past(reg3_sel) == lbw_pkg::REG3_SEL_2V5) ? lbw_pkg::REG3_MV_2V5 :
       lbw_pkg::REG3_MV_DEF))
    else $error("regulator 3 voltage decode wrong");

  a_stepup_top: assert property (
    (rst_n_i && (stepup_sel == 3'h7)) |=> (analog_o.stepup_dv == 8'hA5))
    else $error("step-up code 7 not 16.5 V");

  a_sink_steps: assert property (
    (rst_n_i && $changed(main_current_code_o)) |=>
      (analog_o.sink_steps == 9'({1'b0, $past(main_current_code_o)} + 9'h001)))
    else $error("sink current not code plus one");

  a_sink_extremes: assert property (
    ((rst_n_i && (main_current_code_o == 8'hFF)) |=>
       (analog_o.sink_steps == lbw_pkg::SINK_STEPS_MAX))
    and ((rst_n_i && (main_current_code_o == 8'h00)) |=>
       (analog_o.sink_steps == lbw_pkg::SINK_STEPS_MIN)))
    else $error("sink current extremes wrong");

  a_main_readback: assert property (
    s_rd_main |=> reg_rvalid_o && (reg_rdata_o == $past(main_current_code_o)))
    else $error("main current read-back wrong");

  a_setup_readback: assert property (
    s_wr_setup ##1 s_rd_setup |=> reg_rvalid_o && (reg_rdata_o == $past(reg_wdata_i, 2)))
    else $error("setup read-back differs from last write");

endmodule

// ===== common/lbw_pkg.sv
package lbw_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SETUP    = 8'h04;
  localparam logic [7:0] ADDR_MAIN_CUR = 8'h05;

  // ----------------------------------------------------------------
  // power-on values and unmapped read data
  // ----------------------------------------------------------------
  localparam logic [7:0] SETUP_RST     = 8'hBA;
  localparam logic [7:0] MAIN_CUR_RST  = 8'h01;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // third regulator voltage, in millivolts
  // ----------------------------------------------------------------
  localparam logic [1:0]  REG3_SEL_1V2  = 2'h0;
  localparam logic [1:0]  REG3_SEL_1V5  = 2'h1;
  localparam logic [1:0]  REG3_SEL_DEF  = 2'h2;
  localparam logic [1:0]  REG3_SEL_2V5  = 2'h3;
  localparam logic [11:0] REG3_MV_1V2   = 12'h4B0;
  localparam logic [11:0] REG3_MV_1V5   = 12'h5DC;
  localparam logic [11:0] REG3_MV_DEF   = 12'h708;
  localparam logic [11:0] REG3_MV_2V5   = 12'h9C4;

  // ----------------------------------------------------------------
  // step-up output, in tenths of a volt
  // ----------------------------------------------------------------
  localparam logic [7:0] STEPUP_DV_BASE = 8'h82;
  localparam logic [7:0] STEPUP_DV_STEP = 8'h05;
  localparam logic [7:0] STEPUP_DV_RST  = 8'h8C;

  // ----------------------------------------------------------------
  // main sink current, in 0.1 mA steps
  // ----------------------------------------------------------------
  localparam logic [8:0] SINK_STEPS_RST = 9'h002;
  localparam logic [8:0] SINK_STEPS_MAX = 9'h100;
  localparam logic [8:0] SINK_STEPS_MIN = 9'h001;

  // ----------------------------------------------------------------
  // field layout of the setup register, bit 7 first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic reg3_volt_sel_hi;
    logic reg3_volt_sel_lo;
    logic reg1_active_discharge_en;
    logic reg2_active_discharge_en;
    logic reg3_active_discharge_en;
    logic stepup_volt_sel_b2;
    logic stepup_volt_sel_b1;
    logic stepup_volt_sel_b0;
  } lbw_setup_t;

  // decoded analog settings
  typedef struct packed {
    logic [11:0] reg3_mv;
    logic [7:0]  stepup_dv;
    logic [8:0]  sink_steps;
  } lbw_analog_t;

endpackage

// ===== core/lbw_reg8.sv
module lbw_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       we_i,
  input  wire logic [7:0] d_i,
  output logic      [7:0] q_o
);

  logic [7:0] val_d;
  logic [7:0] val_q;

  // ----------------------------------------------------------------
  // next value: load on write, else hold
  // ----------------------------------------------------------------
  always_comb begin
    val_d = val_q;
    if (we_i) begin
      val_d = d_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign q_o = val_q;

endmodule

// ===== bench/lbw_host_model.sv
// ----------------------------------------------------------------
// host side of the register strobe port
// ----------------------------------------------------------------
module lbw_host_model (
  input  wire logic       clk_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  input  wire logic       reg_miss_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // one access; strobes drop low, address and data lines show the inverse of the last value
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v, output logic m);
    @(posedge clk_i);
    reg_wr_o    <= wr;
    reg_rd_o    <= ~wr;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_rd_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
    #1;
    q = reg_rdata_i;
    v = reg_rvalid_i;
    m = reg_miss_i;
  endtask

  // write then read of one offset on consecutive edges
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v, output logic m);
    @(posedge clk_i);
    reg_wr_o    <= 1'b1;
    reg_rd_o    <= 1'b0;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_rd_o    <= 1'b1;
    @(posedge clk_i);
    reg_rd_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
    #1;
    q = reg_rdata_i;
    v = reg_rvalid_i;
    m = reg_miss_i;
  endtask
endmodule

// ===== bench/tb_lbw_cfg_regs.sv
module tb_lbw_cfg_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // clock, reset, wiring
  // ----------------------------------------------------------------
  logic                 clk_i = 1'b0;
  logic                 rst_n_i = 1'b0;
  logic                 reg_wr, reg_rd, rvalid, miss;
  logic [7:0]           addr, wdata, rdata, main_code, q;
  logic                 v, m;
  lbw_pkg::lbw_setup_t  setup;
  lbw_pkg::lbw_analog_t analog;
  int                   miscompares = 0;
  int                   total_checks = 0;
  logic [11:0]          mv_tab [4] = '{12'h4B0, 12'h5DC, 12'h708, 12'h9C4};

  always #4 clk_i = ~clk_i;

  lbw_cfg_regs lbw_cfg_regs_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_miss_o(miss), .setup_o(setup),
    .main_current_code_o(main_code), .analog_o(analog));

  lbw_host_model lbw_host_model_inst (
    .clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_miss_i(miss));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    settle();
    check(setup, 8'hBA);
    check(main_code, 8'h01);
    check(analog.sink_steps, 9'h002);
    check(analog.stepup_dv, 8'h8C);
    check(analog.reg3_mv, 12'h708);
    lbw_host_model_inst.access(1'b0, 8'h04, 8'h00, q, v, m);
    check({v, m, q}, {2'b10, 8'hBA});
    lbw_host_model_inst.access(1'b0, 8'h05, 8'h00, q, v, m);
    check({v, m, q}, {2'b10, 8'h01});
  endtask

  task automatic test_setup_fields();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], ~i[2:0], i[2:0]};
      lbw_host_model_inst.access(1'b1, 8'h04, d, q, v, m);
      check(setup, d);
      settle();
      check(analog.stepup_dv, 8'h82 + 8'(i) * 8'h05);
      check(analog.reg3_mv, mv_tab[i % 4]);
      lbw_host_model_inst.access(1'b0, 8'h04, 8'h00, q, v, m);
      check({v, m, q}, {2'b10, d});
    end
  endtask

  task automatic test_main_current();
    logic [7:0] codes [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};
    foreach (codes[k]) begin
      lbw_host_model_inst.access(1'b1, 8'h05, codes[k], q, v, m);
      check({m, main_code}, {1'b0, codes[k]});
      settle();
      check(analog.sink_steps, {1'b0, codes[k]} + 9'h001);
      lbw_host_model_inst.access(1'b0, 8'h05, 8'h00, q, v, m);
      check({v, m, q}, {2'b10, codes[k]});
    end
  endtask

  task automatic test_unmapped_and_rereset();
    lbw_host_model_inst.access(1'b1, 8'h06, 8'h55, q, v, m);
    check({m, main_code, setup}, {1'b1, 8'h01, 8'hC7});
    lbw_host_model_inst.access(1'b0, 8'h06, 8'h00, q, v, m);
    check({v, m, q}, {2'b11, 8'h00});
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    check({setup, main_code}, {8'hBA, 8'h01});
    check({rvalid, miss, rdata}, {2'b00, 8'h00});
    check({analog.sink_steps, analog.reg3_mv}, {9'h002, 12'h708});
  endtask

  task automatic test_back_to_back();
    lbw_host_model_inst.wr_rd(8'h04, 8'h65, q, v, m);
    check({v, m, q, setup}, {2'b10, 8'h65, 8'h65});
    check(analog.stepup_dv, 8'h9B);
    check(analog.reg3_mv, 12'h5DC);
    lbw_host_model_inst.wr_rd(8'h05, 8'hA3, q, v, m);
    check({v, m, q, main_code}, {2'b10, 8'hA3, 8'hA3});
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    test_reset_values();
    test_setup_fields();
    test_main_current();
    test_unmapped_and_rereset();
    test_back_to_back();
    print_verdict();
  end

  initial begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
endmodule
